// *** verilog/sdisr_regs.svh ***
// register offsets, field positions, reset values and bus constants
// assumes inclusion by bare name from design files of the serializer control bank
`ifndef SDISR_REGS_SVH
`define SDISR_REGS_SVH
// ==========================================
// register offsets
`define SDISR_OFS_MODE 8'h21
`define SDISR_OFS_MODE_OVR 8'h22
`define SDISR_OFS_BYPASS 8'h24
`define SDISR_OFS_POWER 8'h26
`define SDISR_OFS_EVMASK 8'h27
`define SDISR_OFS_LOSFORCE 8'h28
`define SDISR_OFS_ERRCNT 8'h2b
// ==========================================
// field positions
`define SDISR_BIT_MODE_OVR 0
`define SDISR_BIT_BYPASS 7
`define SDISR_BIT_CHAN_RST 7
`define SDISR_BIT_LOS_LOW 1
`define SDISR_BIT_LOS_HIGH 0
`define SDISR_MODE_ASI 2'h3
// ==========================================
// reset values
`define SDISR_RST_MODE 2'h0
`define SDISR_RST_POWER 7'h3f
`define SDISR_RST_EVMASK 5'h00
`define SDISR_RST_LOSFORCE 2'h0
// ==========================================
// management bus
`define SDISR_SMB_ADDR 7'h2a
`endif

// *** verilog/sdisr_pkg.sv ***
// types shared by the serializer control bank
// assumes the constants header is included where offsets are needed
package sdisr_pkg;
    // ==========================================
    // error event inputs, one-cycle pulses
    typedef struct packed {
        logic pll_err;
        logic fifo_over;
        logic fifo_under;
        logic clk_detect_err;
        logic clk_los;
        logic data_los;
    } sdisr_events_t;
    // ==========================================
    // register request from the management bus slave
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sdisr_regreq_t;
    // ==========================================
    // management bus slave states
    typedef enum logic [3:0] {
        SDISR_IDLE, SDISR_DEV, SDISR_ACK_DEV, SDISR_REG, SDISR_ACK_REG,
        SDISR_WDATA, SDISR_ACK_WR, SDISR_RDATA, SDISR_ACK_RD
    } sdisr_smb_state_t;
endpackage

// *** verilog/sdisr_err_counter.sv ***
// saturating error event counter
// assumes inc and clr are synchronous one-cycle pulses
`timescale 1ns/1ns
module sdisr_err_counter #(
    parameter int CNT_W = 8
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic inc_in,
    input wire logic clr_in,
    output logic [CNT_W-1:0] count_out
);
    // ==========================================
    // parameter check
    if (CNT_W < 1) begin : g_bad_width
        $error("counter width must be at least one");
    end
    // ==========================================
    // count, a clear with a coincident event loads one so no event is lost
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_out <= '0;
        end else if (clr_in) begin
            count_out <= {{(CNT_W-1){1'b0}}, inc_in};
        end else if (inc_in && !(&count_out)) begin
            count_out <= count_out + 1'b1; // holds at all ones
        end
    end
endmodule

// *** verilog/sdisr_smbus.sv ***
// management bus slave: device address, register pointer, data bytes
// assumes scl and sda are already synchronous to clk_sys_in
`timescale 1ns/1ns
`include "sdisr_regs.svh"
module sdisr_smbus #(
    parameter logic [6:0] DEV_ADDR = `SDISR_SMB_ADDR
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic cs_in,
    input wire logic [7:0] rdata_in,
    output logic sda_out,
    output logic sda_oe_out,
    output sdisr_pkg::sdisr_regreq_t req_out
);
    sdisr_pkg::sdisr_smb_state_t state_q;
    logic scl_p_q, sda_p_q, rw_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    // ==========================================
    // bus conditions from the previous sample
    assign scl_rise = scl_in && !scl_p_q;
    assign scl_fall = !scl_in && scl_p_q;
    assign start_seen = scl_in && scl_p_q && sda_p_q && !sda_in;
    assign stop_seen = scl_in && scl_p_q && !sda_p_q && sda_in;
    // previous line levels
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            sda_out <= 1'b0;
        end else begin
            scl_p_q <= scl_in;
            sda_p_q <= sda_in;
            sda_out <= 1'b0; // open drain: only ever pulls low
        end
    end
    // ==========================================
    // byte sequencer; repeated start restarts from the address byte
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= sdisr_pkg::SDISR_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            rw_q <= 1'b0;
            sda_oe_out <= 1'b0;
            req_out <= '0;
        end else begin
            req_out.wr <= 1'b0;
            if (!cs_in || stop_seen) begin
                state_q <= sdisr_pkg::SDISR_IDLE;
                sda_oe_out <= 1'b0;
            end else if (start_seen) begin
                state_q <= sdisr_pkg::SDISR_DEV;
                cnt_q <= 4'h0;
                sda_oe_out <= 1'b0;
            end else if (scl_rise) begin
                case (state_q)
                    sdisr_pkg::SDISR_DEV, sdisr_pkg::SDISR_REG,
                    sdisr_pkg::SDISR_WDATA: begin
                        sh_q <= {sh_q[6:0], sda_in};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    sdisr_pkg::SDISR_ACK_RD: begin
                        rw_q <= !sda_in; // reuse: master acked, keep reading
                        if (!sda_in) begin
                            req_out.addr <= req_out.addr + 8'h01;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state_q)
                    sdisr_pkg::SDISR_DEV: begin
                        if (cnt_q == 4'h8) begin
                            if (sh_q[7:1] == DEV_ADDR) begin
                                state_q <= sdisr_pkg::SDISR_ACK_DEV;
                                rw_q <= sh_q[0];
                                sda_oe_out <= 1'b1;
                            end else begin
                                state_q <= sdisr_pkg::SDISR_IDLE;
                            end
                        end
                    end
                    sdisr_pkg::SDISR_ACK_DEV, sdisr_pkg::SDISR_ACK_RD: begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            state_q <= sdisr_pkg::SDISR_RDATA;
                            sh_q <= rdata_in;
                            sda_oe_out <= !rdata_in[7];
                        end else begin
                            sda_oe_out <= 1'b0;
                            state_q <= (state_q == sdisr_pkg::SDISR_ACK_DEV) ?
                                sdisr_pkg::SDISR_REG : sdisr_pkg::SDISR_IDLE;
                        end
                    end
                    sdisr_pkg::SDISR_REG, sdisr_pkg::SDISR_WDATA: begin
                        if (cnt_q == 4'h8) begin
                            sda_oe_out <= 1'b1;
                            if (state_q == sdisr_pkg::SDISR_REG) begin
                                state_q <= sdisr_pkg::SDISR_ACK_REG;
                                req_out.addr <= sh_q;
                            end else begin
                                state_q <= sdisr_pkg::SDISR_ACK_WR;
                                req_out.wdata <= sh_q;
                                req_out.wr <= 1'b1;
                            end
                        end
                    end
                    sdisr_pkg::SDISR_ACK_REG: begin
                        state_q <= sdisr_pkg::SDISR_WDATA;
                        cnt_q <= 4'h0;
                        sda_oe_out <= 1'b0;
                    end
                    sdisr_pkg::SDISR_ACK_WR: begin
                        state_q <= sdisr_pkg::SDISR_WDATA;
                        cnt_q <= 4'h0;
                        sda_oe_out <= 1'b0;
                        req_out.addr <= req_out.addr + 8'h01; // auto increment
                    end
                    sdisr_pkg::SDISR_RDATA: begin
                        if (cnt_q == 4'h7) begin
                            state_q <= sdisr_pkg::SDISR_ACK_RD;
                            sda_oe_out <= 1'b0;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            sda_oe_out <= !sh_q[6];
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule

// *** verilog/sdisr_ctrl.sv ***
// serializer control register bank behind the management bus
// assumes pins and event pulses are synchronous to clk_sys_in
`timescale 1ns/1ns
`include "sdisr_regs.svh"
// What this block does
// [R1] With the override bit set the operating mode comes from the mode register, else from the pin.
// [R2] A mode field of 11 selects the asynchronous serial mode, any other value selects SDI.
// [R3] Bypass bit 7 routes the link clock around the programmable delay when set.
// [R4] Power register bit 7 is a channel reset, cleared at reset, pulsed by software on mode change.
// [R5] Software sets and later clears the channel reset, which holds the channel until then.
// [R6] Power-down bits 6:0 disable serializer parts individually and reset to 0x3f.
// [R7] Software writes only bit 6 or all zeros to the power register to save power.
// [R8] An all-zero power register puts the device into standby.
// [R9] FIFO overflow, underflow and signal or clock losses are counted unless masked.
// [R10] Mask bit 4 stops PLL clock errors from being counted.
// [R11] Mask bit 3 stops FIFO errors from being counted.
// [R12] Mask bit 2 stops link clock detect errors from being counted.
// [R13] Mask bit 1 stops clock signal-loss errors from being counted.
// [R14] Mask bit 0 stops data signal-loss errors from being counted.
// [R15] With both force bits clear the loss indicator follows detection.
// [R16] Force bit 1 drives the loss indicator low.
// [R17] Force bit 0 drives the loss indicator high and wins over bit 1.
module sdisr_ctrl #(
    parameter logic [6:0] DEV_ADDR = `SDISR_SMB_ADDR,
    parameter int CNT_W = 8
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic smb_scl_in,
    input wire logic smb_sda_in,
    input wire logic smb_cs_in,
    output logic smb_sda_out,
    output logic smb_sda_oe_out,
    input wire logic asi_pin_in,
    input wire logic los_detect_in,
    input wire sdisr_pkg::sdisr_events_t events_in,
    output logic asi_mode_out,
    output logic clk_delay_bypass_out,
    output logic channel_reset_out,
    output logic [6:0] power_down_out,
    output logic standby_out,
    output logic los_out,
    output logic [CNT_W-1:0] error_count_out
);
    // ==========================================
    // parameter check
    if (CNT_W < 1 || CNT_W > 8) begin : g_bad_cnt
        $error("error counter must fit one register byte");
    end

    sdisr_pkg::sdisr_regreq_t req;
    logic [7:0] rdata;
    logic [1:0] mode_q;
    logic mode_ovr_q;
    logic [4:0] clock_detect_error_mask_q; // full event mask, bit 2 is clock detect
    logic [1:0] los_force_q;
    logic [4:0] ev_raw, ev_hit;
    logic cnt_clr;

    // ==========================================
    // decode helpers
    function automatic logic hit(input sdisr_pkg::sdisr_regreq_t r, input logic [7:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction

    function automatic logic [7:0] read_reg(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `SDISR_OFS_MODE: v = {6'h00, {2{asi_mode_out}}};
            `SDISR_OFS_MODE_OVR: v = {7'h00, mode_ovr_q};
            `SDISR_OFS_BYPASS: v = {clk_delay_bypass_out, 7'h00};
            `SDISR_OFS_POWER: v = {channel_reset_out, power_down_out};
            `SDISR_OFS_EVMASK: v = {3'h0, clock_detect_error_mask_q};
            `SDISR_OFS_LOSFORCE: v = {6'h00, los_force_q};
            `SDISR_OFS_ERRCNT: v = 8'(error_count_out);
            default: v = 8'h00; // reserved and unmapped read zero
        endcase
        read_reg = v;
    endfunction

    // ==========================================
    // management bus slave
    sdisr_smbus #(
        .DEV_ADDR(DEV_ADDR)
    ) u_smbus (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .scl_in(smb_scl_in),
        .sda_in(smb_sda_in),
        .cs_in(smb_cs_in),
        .rdata_in(rdata),
        .sda_out(smb_sda_out),
        .sda_oe_out(smb_sda_oe_out),
        .req_out(req)
    );

    // read data follows the live register pointer
    always_comb rdata = read_reg(req.addr);

    // ==========================================
    // mode registers
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_q <= `SDISR_RST_MODE;
            mode_ovr_q <= 1'b0;
        end else begin
            if (hit(req, `SDISR_OFS_MODE)) begin
                mode_q <= req.wdata[1:0];
            end
            if (hit(req, `SDISR_OFS_MODE_OVR)) begin
                mode_ovr_q <= req.wdata[`SDISR_BIT_MODE_OVR];
            end
        end
    end

    // [R1] [R2] mode source and decode
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            asi_mode_out <= 1'b0;
        end else if (mode_ovr_q) begin
            asi_mode_out <= (mode_q == `SDISR_MODE_ASI);
        end else begin
            asi_mode_out <= asi_pin_in;
        end
    end

    // ==========================================
    // [R3] link clock delay bypass
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clk_delay_bypass_out <= 1'b0;
        end else if (hit(req, `SDISR_OFS_BYPASS)) begin
            clk_delay_bypass_out <= req.wdata[`SDISR_BIT_BYPASS];
        end
    end

    // ==========================================
    // [R4] [R6] channel reset and power-down bits
    // the channel reset is a plain level so software alone decides the pulse length
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            channel_reset_out <= 1'b0;
            power_down_out <= `SDISR_RST_POWER;
        end else if (hit(req, `SDISR_OFS_POWER)) begin
            channel_reset_out <= req.wdata[`SDISR_BIT_CHAN_RST];
            power_down_out <= req.wdata[6:0];
        end
    end

    // [R8] standby when the whole power register is zero
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            standby_out <= 1'b0;
        end else begin
            standby_out <= !channel_reset_out && (power_down_out == 7'h00);
        end
    end

    // ==========================================
    // event mask and loss force registers
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clock_detect_error_mask_q <= `SDISR_RST_EVMASK;
            los_force_q <= `SDISR_RST_LOSFORCE;
        end else begin
            if (hit(req, `SDISR_OFS_EVMASK)) begin
                clock_detect_error_mask_q <= req.wdata[4:0];
            end
            if (hit(req, `SDISR_OFS_LOSFORCE)) begin
                los_force_q <= req.wdata[1:0];
            end
        end
    end

    // [R9] event sources, one per mask bit; both fifo faults share one bit
    assign ev_raw = {events_in.pll_err,
                     events_in.fifo_over || events_in.fifo_under,
                     events_in.clk_detect_err,
                     events_in.clk_los,
                     events_in.data_los};

    // [R10] [R11] [R12] [R13] [R14] per-source masking
    for (genvar i = 0; i < 5; i++) begin : g_mask
        assign ev_hit[i] = ev_raw[i] && !clock_detect_error_mask_q[i];
    end

    // a write to the count register clears it; simultaneous events count one
    assign cnt_clr = hit(req, `SDISR_OFS_ERRCNT);

    // [R9] unmasked events counted, at most one per cycle
    sdisr_err_counter #(
        .CNT_W(CNT_W)
    ) u_count (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .inc_in(|ev_hit),
        .clr_in(cnt_clr),
        .count_out(error_count_out)
    );

    // ==========================================
    // [R15] [R16] [R17] loss indicator with forcing, high force wins
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            los_out <= 1'b0;
        end else if (los_force_q[`SDISR_BIT_LOS_HIGH]) begin
            los_out <= 1'b1;
        end else if (los_force_q[`SDISR_BIT_LOS_LOW]) begin
            los_out <= 1'b0;
        end else begin
            los_out <= los_detect_in;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    sequence s_power_wr(logic [7:0] d);
        req.wr && req.addr == `SDISR_OFS_POWER && req.wdata == d;
    endsequence

    sequence s_ev_unmasked;
        (|ev_hit) && !cnt_clr && !(&error_count_out);
    endsequence

    a_mode_override: assert property ( // [R1]
        mode_ovr_q && !$changed(mode_q) && $stable(mode_ovr_q) ##1 mode_ovr_q
        |-> asi_mode_out == ($past(mode_q) == `SDISR_MODE_ASI))
        else $error("mode not taken from register under override");
    a_mode_pin: assert property ( // [R1]
        !mode_ovr_q |=> asi_mode_out == $past(asi_pin_in))
        else $error("mode does not follow pin");
    a_mode_decode: assert property ( // [R2]
        mode_ovr_q && mode_q != `SDISR_MODE_ASI |=> !asi_mode_out)
        else $error("non-asi code selected asi mode");
    a_delay_bypass: assert property ( // [R3]
        hit(req, `SDISR_OFS_BYPASS) |=> clk_delay_bypass_out == $past(req.wdata[7]))
        else $error("bypass bit not applied");
    a_chan_reset_hold: assert property ( // [R4]
        channel_reset_out && !hit(req, `SDISR_OFS_POWER) |=> channel_reset_out)
        else $error("channel reset dropped without a write");
    a_power_write: assert property ( // [R6]
        hit(req, `SDISR_OFS_POWER) |=> power_down_out == $past(req.wdata[6:0]))
        else $error("power-down bits not written");
    a_standby_entry: assert property ( // [R8]
        s_power_wr(8'h00) ##1 !hit(req, `SDISR_OFS_POWER) |=> standby_out)
        else $error("all-zero power write did not enter standby");
    a_event_count: assert property ( // [R9]
        s_ev_unmasked |=> error_count_out == $past(error_count_out) + 1'b1)
        else $error("unmasked event not counted");
    a_event_masked: assert property ( // [R10]
        !(|ev_hit) && !cnt_clr |=> $stable(error_count_out))
        else $error("masked or absent event changed the count");
    a_los_high: assert property ( // [R17]
        los_force_q[`SDISR_BIT_LOS_HIGH] |=> los_out)
        else $error("loss indicator not forced high");
    a_los_low: assert property ( // [R16]
        los_force_q == 2'h2 |=> !los_out)
        else $error("loss indicator not forced low");
    a_los_follow: assert property ( // [R15]
        los_force_q == 2'h0 |=> los_out == $past(los_detect_in))
        else $error("loss indicator does not follow detection");
endmodule

// *** tb/sdisr_host.sv ***
// management bus master model standing in for the host
// assumes an external pull-up wire that merges both open-drain drivers
`timescale 1ns/1ns
module sdisr_host #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input wire logic clk_sys_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // ==========================================
    // bus idle: both lines released
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // ==========================================
    // bit level, every change on a falling clock edge
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // sda settles two cycles before scl rises, so no false start or stop
    task automatic put_bit(input logic b);
        sda_low_out = ~b;
        tick(2);
        scl_out = 1'b1;
        tick(4);
        scl_out = 1'b0;
        tick(2);
    endtask
    task automatic get_bit(output logic b);
        sda_low_out = 1'b0;
        tick(2);
        scl_out = 1'b1;
        tick(2);
        b = sda_in;
        tick(2);
        scl_out = 1'b0;
        tick(2);
    endtask
    // also serves as repeated start
    task automatic start_cond();
        sda_low_out = 1'b0;
        tick(2);
        scl_out = 1'b1;
        tick(4);
        sda_low_out = 1'b1;
        tick(4);
        scl_out = 1'b0;
        tick(2);
    endtask
    task automatic stop_cond();
        sda_low_out = 1'b1;
        tick(2);
        scl_out = 1'b1;
        tick(4);
        sda_low_out = 1'b0;
        tick(4);
    endtask
    // ==========================================
    // byte and register transfers, msb first
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(a);
        ack = ~a;
    endtask
    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start_cond();
        put_byte({DEV_ADDR, 1'b0}, a0);
        put_byte(ofs, a1);
        put_byte(d, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
    // single byte read ends with a nack so the slave lets go
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] v, output logic ok);
        logic a0, a1, a2, b;
        start_cond();
        put_byte({DEV_ADDR, 1'b0}, a0);
        put_byte(ofs, a1);
        start_cond();
        put_byte({DEV_ADDR, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) begin
            get_bit(b);
            v[i] = b;
        end
        put_bit(1'b1);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the serializer control bank
// assumes the host model reaches the registers over the management bus
`timescale 1ns/1ns
`include "sdisr_regs.svh"
module tb;
    logic clk_sys_in, nrst_in, smb_cs_in, asi_pin_in, los_detect_in;
    sdisr_pkg::sdisr_events_t events_in;
    logic smb_sda_out, smb_sda_oe_out, asi_mode_out, clk_delay_bypass_out;
    logic channel_reset_out, standby_out, los_out;
    logic [6:0] power_down_out;
    logic [7:0] error_count_out;
    logic scl, host_low;
    wire sda_line = ~(host_low | (smb_sda_oe_out & ~smb_sda_out)); // pull-up wins when nobody pulls
    int failures = 0;
    int check_count = 0;
    sdisr_ctrl i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .smb_scl_in(scl),
        .smb_sda_in(sda_line), .smb_cs_in(smb_cs_in), .smb_sda_out(smb_sda_out),
        .smb_sda_oe_out(smb_sda_oe_out), .asi_pin_in(asi_pin_in),
        .los_detect_in(los_detect_in), .events_in(events_in), .asi_mode_out(asi_mode_out),
        .clk_delay_bypass_out(clk_delay_bypass_out), .channel_reset_out(channel_reset_out),
        .power_down_out(power_down_out), .standby_out(standby_out), .los_out(los_out),
        .error_count_out(error_count_out));
    sdisr_host i_host (.clk_sys_in(clk_sys_in), .sda_in(sda_line), .scl_out(scl),
        .sda_low_out(host_low));
    // ==========================================
    // clock and shared helpers
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic ok;
        i_host.write_reg(ofs, d, ok);
        chk({7'h00, ok}, 8'h01, "write ack");
    endtask
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp, input string what);
        logic [7:0] v;
        logic ok;
        i_host.read_reg(ofs, v, ok);
        chk({7'h00, ok}, 8'h01, "read ack");
        chk(v, exp, what);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        rd(`SDISR_OFS_BYPASS, 8'h00, "bypass reset");
        rd(`SDISR_OFS_POWER, 8'h3f, "power reset");
        rd(`SDISR_OFS_EVMASK, 8'h00, "mask reset");
        rd(`SDISR_OFS_LOSFORCE, 8'h00, "force reset");
        rd(`SDISR_OFS_MODE_OVR, 8'h00, "override reset");
        chk({1'b0, power_down_out}, 8'h3f, "power pins");
        wr(8'h25, 8'hff); // unmapped place swallows writes
        rd(8'h25, 8'h00, "unmapped read");
    endtask
    task automatic t_mode();
        asi_pin_in = 1'b1;
        i_host.tick(2);
        chk({7'h00, asi_mode_out}, 8'h01, "pin mode");
        wr(`SDISR_OFS_MODE_OVR, 8'h01);
        for (int v = 0; v < 4; v++) begin
            wr(`SDISR_OFS_MODE, 8'(v));
            chk({7'h00, asi_mode_out}, {7'h00, v == 3}, "reg mode");
            rd(`SDISR_OFS_MODE, {6'h00, {2{v == 3}}}, "mode rd");
        end
        // channel reset pulse around the mode switch
        wr(`SDISR_OFS_POWER, 8'hbf);
        chk({7'h00, channel_reset_out}, 8'h01, "chan reset held");
        wr(`SDISR_OFS_POWER, 8'h3f);
        chk({7'h00, channel_reset_out}, 8'h00, "chan reset clear");
        wr(`SDISR_OFS_MODE, 8'h00);
        wr(`SDISR_OFS_MODE_OVR, 8'h00);
        chk({7'h00, asi_mode_out}, 8'h01, "back to pin");
    endtask
    task automatic t_power();
        wr(`SDISR_OFS_POWER, 8'h40);
        chk({standby_out, power_down_out}, 8'h40, "low power");
        wr(`SDISR_OFS_POWER, 8'h00);
        chk({standby_out, power_down_out}, 8'h80, "standby");
        wr(`SDISR_OFS_POWER, 8'h3f);
        chk({standby_out, power_down_out}, 8'h3f, "normal");
    endtask
    task automatic t_bypass();
        logic ok;
        smb_cs_in = 1'b0; // deselected slave must not answer
        i_host.write_reg(`SDISR_OFS_BYPASS, 8'h80, ok);
        chk({6'h00, ok, clk_delay_bypass_out}, 8'h00, "deselected");
        smb_cs_in = 1'b1;
        wr(`SDISR_OFS_BYPASS, 8'h80);
        chk({7'h00, clk_delay_bypass_out}, 8'h01, "bypass on");
        wr(`SDISR_OFS_BYPASS, 8'h00);
        chk({7'h00, clk_delay_bypass_out}, 8'h00, "bypass off");
    endtask
    task automatic pulse(input int e);
        @(negedge clk_sys_in) events_in = sdisr_pkg::sdisr_events_t'(6'h01 << e);
        @(negedge clk_sys_in) events_in = '0;
        @(negedge clk_sys_in);
    endtask
    // fifo over and under share one mask bit
    task automatic t_events();
        int m;
        for (int e = 0; e < 6; e++) begin
            m = (e >= 4) ? e - 1 : e;
            wr(`SDISR_OFS_EVMASK, 8'h00);
            wr(`SDISR_OFS_ERRCNT, 8'h00);
            pulse(e);
            chk(error_count_out, 8'h01, "counted");
            rd(`SDISR_OFS_ERRCNT, 8'h01, "cnt rd");
            wr(`SDISR_OFS_EVMASK, 8'h01 << m);
            wr(`SDISR_OFS_ERRCNT, 8'h00);
            pulse(e);
            chk(error_count_out, 8'h00, "masked");
        end
        wr(`SDISR_OFS_EVMASK, 8'h00);
    endtask
    task automatic t_los();
        for (int f = 0; f < 4; f++) begin
            wr(`SDISR_OFS_LOSFORCE, 8'(f));
            for (int d = 0; d < 2; d++) begin
                los_detect_in = d[0];
                i_host.tick(2);
                chk({7'h00, los_out}, {7'h00, f[0] | (~f[1] & d[0])}, "los");
            end
        end
    endtask
    // ==========================================
    // verdict and main sequence
    task automatic end_of_test();
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        nrst_in = 1'b0;
        smb_cs_in = 1'b1;
        asi_pin_in = 1'b0;
        los_detect_in = 1'b0;
        events_in = '0;
        repeat (3) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        i_host.tick(2);
        t_reset();
        t_mode();
        t_power();
        t_bypass();
        t_events();
        t_los();
        end_of_test();
    end
    // ~16k cycles expected
    initial begin
        #1_000_000;
        failures++;
        end_of_test();
    end
endmodule
